// file: hw/eais_defines.svh
`ifndef EAIS_DEFINES_SVH
`define EAIS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EAIS_IDX_MODE     16'he702
`define EAIS_IDX_WIRE     16'he710
`define EAIS_IDX_LCLEN    16'he711
`define EAIS_IDX_ZXCNT    16'he712
`define EAIS_IDX_VBRMS    16'he713
`define EAIS_IDX_ENERGY0  16'he720
`define EAIS_NUM_ENERGY   16'h0009

// ----------------------------------------------------------------------
// Line-cycle mode register fields and reset values
// ----------------------------------------------------------------------
`define EAIS_MODE_ACTIVE  0
`define EAIS_MODE_REACT   1
`define EAIS_MODE_APPAR   2
`define EAIS_MODE_ZX_LO   3
`define EAIS_MODE_ZX_HI   5
`define EAIS_MODE_RDCLR   6
`define EAIS_MODE_RSVD    7
`define EAIS_MODE_RST     8'h78
`define EAIS_MODE_WMASK   8'h7f
`define EAIS_WIRE_RST     2'h0
`define EAIS_LCLEN_RST    16'h0064

`endif

// file: hw/eais_pkg.sv
package eais_pkg;

    // Wiring configurations of the meter
    typedef enum logic [1:0] {
        EAIS_WYE_3VS,
        EAIS_DELTA_3W,
        EAIS_WYE_2VS,
        EAIS_DELTA_4W
    } eais_wiring_t;

endpackage

// file: hw/eais_sel_if.sv
`timescale 1ns/1ps
interface eais_sel_if #(parameter int W = 16);
    localparam int PW = 2 * W + 2;
    logic                  valid;
    logic [1:0]            wiring;
    logic [2:0][W-1:0]     v;
    logic [2:0][W-1:0]     i;
    logic [2:0][W-1:0]     iq;
    logic [2:0][W-1:0]     vrms;
    logic [2:0][W-1:0]     irms;
    logic [8:0][PW-1:0]    prod;
    logic                  prod_valid;
    logic [W:0]            vb_sel;

    modport top (output valid, wiring, v, i, iq, vrms, irms,
                 input  prod, prod_valid, vb_sel);
    modport sel (input  valid, wiring, v, i, iq, vrms, irms,
                 output prod, prod_valid, vb_sel);
endinterface

// file: hw/eais_operand_sel.sv
`timescale 1ns/1ps
module eais_operand_sel
    import eais_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk_i,      // DSP clock
    input wire logic resetn_i,   // Async reset, active low
    eais_sel_if.sel  sel_if      // Operands in, products out
);
    localparam int PW = 2 * W + 2;

    typedef struct packed {
        logic               valid;
        logic [W:0]         vb;
        logic [8:0][PW-1:0] prod;
    } eais_sel_state_t;

    eais_sel_state_t s_q;
    eais_sel_state_t s_d;

    // Phase B voltage as the wiring code dictates
    function automatic logic signed [W:0] phase_b_volt(
        input logic [1:0]          code,
        input logic signed [W-1:0] va,
        input logic signed [W-1:0] vb,
        input logic signed [W-1:0] vc);
        logic signed [W:0] r;
        unique case (eais_wiring_t'(code))
            EAIS_WYE_3VS:  r = (W+1)'(vb);
            EAIS_DELTA_3W: r = (W+1)'(va) - (W+1)'(vc);
            EAIS_WYE_2VS:  r = -(W+1)'(va) - (W+1)'(vc);
            EAIS_DELTA_4W: r = -(W+1)'(va);
        endcase
        return r;
    endfunction

    // Signed product at full width
    // Product formed in a full-width variable so no top bits are lost
    function automatic logic [PW-1:0] mul(input logic signed [W:0] a,
                                          input logic signed [W:0] b);
        logic signed [PW-1:0] p;
        p = a * b;
        return p;
    endfunction

    // ------------------------------------------------------------------
    // Operand selection and products
    // ------------------------------------------------------------------
    // Products are registered so the accumulators see a clean pipeline
    always_comb begin
        logic signed [W:0] vb;
        s_d = s_q;
        vb = phase_b_volt(sel_if.wiring, $signed(sel_if.v[0]),
                          $signed(sel_if.v[1]), $signed(sel_if.v[2]));
        s_d.valid = sel_if.valid;
        if (sel_if.valid) begin
            s_d.vb = vb;
            // Active: phases A and C fixed, B substituted
            s_d.prod[0] = mul($signed(sel_if.v[0]), $signed(sel_if.i[0]));
            s_d.prod[1] = mul(vb, $signed(sel_if.i[1]));
            s_d.prod[2] = mul($signed(sel_if.v[2]), $signed(sel_if.i[2]));
            // Reactive: voltage times current lagged by ninety degrees
            s_d.prod[3] = mul($signed(sel_if.v[0]), $signed(sel_if.iq[0]));
            s_d.prod[4] = mul(vb, $signed(sel_if.iq[1]));
            s_d.prod[5] = mul($signed(sel_if.v[2]), $signed(sel_if.iq[2]));
            // Apparent: rms values are magnitudes, never negative
            s_d.prod[6] = mul({1'b0, sel_if.vrms[0]}, {1'b0, sel_if.irms[0]});
            s_d.prod[7] = mul({1'b0, sel_if.vrms[1]}, {1'b0, sel_if.irms[1]});
            s_d.prod[8] = mul({1'b0, sel_if.vrms[2]}, {1'b0, sel_if.irms[2]});
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sel_if.prod       = s_q.prod;
    assign sel_if.prod_valid = s_q.valid;
    assign sel_if.vb_sel     = s_q.vb;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_phase_a_active: assert property (sel_if.valid |=>
        s_q.prod[0] == $past(mul($signed(sel_if.v[0]), $signed(sel_if.i[0]))))
        else $error("phase A active product wrong");
    a_phase_b_subst: assert property (
        sel_if.valid && sel_if.wiring == 2'h1 |=>
        $signed(s_q.vb) == $past((W+1)'($signed(sel_if.v[0]))
                                 - (W+1)'($signed(sel_if.v[2]))))
        else $error("phase B delta voltage wrong");
    a_reactive_b_sel: assert property (sel_if.valid |=>
        s_q.prod[4] == mul($signed(s_q.vb), $past($signed(sel_if.iq[1]))))
        else $error("phase B reactive product wrong");
endmodule

// file: hw/eais_top.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "eais_defines.svh"
// Operation
// - Phase A and C active energy always use own voltage times current.
// - Phase B voltage: VB, VA-VC, -VA-VC or -VA by wiring code.
// - Reactive energy uses voltage times quadrature current, same B substitution.
// - Apparent energy uses voltage rms times current rms, B substituted.
// - Three-wire mode puts rms of VA-VC into phase B voltage rms.
// - Mode register at 0xE702, eight bits, resets to 0x78.
// - Bit 0 switches watt-hour accumulators between regular and line-cycle.
// - Bit 1 switches var-hour accumulators; stays zero without reactive energy.
// - Bit 2 switches VA-hour accumulators between regular and line-cycle.
// - Bits 3 to 5 enable zero-crossing counting for phases A, B, C.
// - Crossings of all enabled phases add, shortening the line-cycle period.
// - With bit 6 set, reading an energy register returns then clears it.
// - Bit 7 is reserved, resets to zero and controls nothing.
// - Quadrature current is the phase current shifted by minus ninety degrees.
// - Wiring codes: wye three sensors, delta, wye two sensors, four-wire delta.
module eais_top
    import eais_pkg::*;
#(
    parameter int W            = 16,  // Sample width
    parameter bit HAS_REACTIVE = 1'b1 // Reactive energy present
) (
    input  wire logic              clk_i,         // DSP clock, 100 MHz
    input  wire logic              resetn_i,      // Async reset, active low
    input  wire logic              wb_cyc_i,      // Wishbone cycle
    input  wire logic              wb_stb_i,      // Wishbone strobe
    input  wire logic              wb_we_i,       // Wishbone write
    input  wire logic [17:0]       wb_adr_i,      // Wishbone byte address
    input  wire logic [3:0]        wb_sel_i,      // Wishbone byte lanes
    input  wire logic [31:0]       wb_dat_i,      // Wishbone write data
    output logic      [31:0]       wb_dat_o,      // Wishbone read data
    output logic                   wb_ack_o,      // Wishbone acknowledge
    input  wire logic              sample_valid_i,// New DSP sample set
    input  wire logic [2:0][W-1:0] volt_i,        // Phase voltages C..A
    input  wire logic [2:0][W-1:0] curr_i,        // Phase currents C..A
    input  wire logic [2:0][W-1:0] curr_quad_i,   // Currents lagged 90 deg
    input  wire logic [2:0][W-1:0] volt_rms_i,    // Voltage rms C..A
    input  wire logic [2:0][W-1:0] curr_rms_i,    // Current rms C..A
    input  wire logic [2:0]        zero_cross_i,  // Polarity of each phase
    output logic      [W:0]        vb_sel_o,      // Phase B voltage to rms
    output logic      [1:0]        wiring_config_code_o, // Wiring code
    output logic                   line_cycle_end_o      // Period end pulse
);
    localparam int AW = 32;
    localparam int PW = 2 * W + 2;

    typedef struct packed {
        logic [7:0]         mode;    // Register as written
        logic [6:0]         eff;     // Copy in force
        logic [1:0]         wire_cd;
        logic [15:0]        lclen;
        logic [15:0]        zxcnt;
        logic [2:0]         zx_m;    // Synchroniser first stage
        logic [2:0]         zx_s;
        logic [2:0]         zx_p;
        logic [8:0][AW-1:0] pub;     // Software-visible energies
        logic [8:0][AW-1:0] run;     // Line-cycle running sums
        logic [W-1:0]       vbrms;
        logic               ack;
        logic [31:0]        rdat;
        logic               lc_end;
    } eais_top_state_t;

    eais_top_state_t s_q;
    eais_top_state_t s_d;
    eais_sel_if #(.W(W)) sel_if ();

    // Number of set bits among three
    function automatic logic [1:0] count3(input logic [2:0] b);
        return 2'({1'b0, b[0]} + {1'b0, b[1]} + {1'b0, b[2]});
    endfunction

    // Product scaled onto the accumulator width
    function automatic logic [AW-1:0] to_acc(input logic [PW-1:0] p);
        return p[PW-1 -: AW];
    endfunction

    // Energy index that a register index selects, or all ones
    function automatic logic [3:0] energy_of(input logic [15:0] idx);
        logic [15:0] off;
        off = idx - `EAIS_IDX_ENERGY0;
        if (idx >= `EAIS_IDX_ENERGY0 && off < `EAIS_NUM_ENERGY) begin
            return off[3:0];
        end
        return 4'hf;
    endfunction

    // ------------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------------
    eais_operand_sel #(.W(W)) u_sel (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .sel_if   (sel_if)
    );

    // Wiring code in force straight from its register
    assign sel_if.valid  = sample_valid_i;
    assign sel_if.wiring = s_q.wire_cd;
    assign sel_if.v      = volt_i;
    assign sel_if.i      = curr_i;
    assign sel_if.iq     = curr_quad_i;
    assign sel_if.vrms   = volt_rms_i;
    assign sel_if.irms   = curr_rms_i;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [15:0] idx;
    logic        req;
    logic        rd_clr;
    logic [3:0]  rd_energy;
    logic [2:0]  zx_edge;
    logic [16:0] zx_sum;
    logic        period_end;

    assign idx       = wb_adr_i[17:2];
    assign req       = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign rd_energy = energy_of(idx);
    // Read-clear follows the copy in force
    assign rd_clr    = req && !wb_we_i && s_q.eff[`EAIS_MODE_RDCLR]
                       && rd_energy != 4'hf;
    // Edges only from the second synchroniser stage onward
    assign zx_edge   = (s_q.zx_s ^ s_q.zx_p)
                       & s_q.eff[`EAIS_MODE_ZX_HI:`EAIS_MODE_ZX_LO];
    // Every enabled phase adds to the count
    assign zx_sum    = {1'b0, s_q.zxcnt} + 17'(count3(zx_edge));
    assign period_end = zx_edge != 3'h0 && zx_sum >= {1'b0, s_q.lclen};

    always_comb begin
        logic [AW-1:0] add;
        logic [AW-1:0] base;
        logic          lc;
        logic [1:0]    ty;
        s_d = s_q;
        add = '0;
        base = '0;
        lc = 1'b0;
        ty = 2'h0;

        // Zero-crossing inputs cross into the clock domain here
        s_d.zx_m = zero_cross_i;
        s_d.zx_s = s_q.zx_m;
        s_d.zx_p = s_q.zx_s;
        s_d.zxcnt = period_end ? 16'h0 : zx_sum[15:0];
        s_d.lc_end = period_end;

        // Accumulators: regular adds each sample, line-cycle once a period
        for (int k = 0; k < 9; k++) begin
            ty = 2'(k / 3);
            lc = s_q.eff[ty];
            add = sel_if.prod_valid ? to_acc(sel_if.prod[k]) : '0;
            base = (rd_clr && rd_energy == 4'(k)) ? '0 : s_q.pub[k];
            if (lc) begin
                s_d.run[k] = period_end ? '0 : s_q.run[k] + add;
                s_d.pub[k] = period_end ? s_q.run[k] + add : base;
            end else begin
                s_d.run[k] = '0;
                s_d.pub[k] = base + add;
            end
            // Type select swaps only at that type's own update
            if (lc ? period_end : sel_if.prod_valid) begin
                s_d.eff[ty] = s_q.mode[ty];
            end
        end
        if (sel_if.prod_valid || period_end) begin
            s_d.eff[6:3] = s_q.mode[6:3];
        end

        // Phase B rms comes back from the rms engine fed by vb_sel_o
        if (sample_valid_i) begin
            s_d.vbrms = volt_rms_i[1];
        end

        // Bus slave: one wait state, unmapped reads give zero
        s_d.ack = req;
        if (req && !wb_we_i) begin
            s_d.rdat = 32'h0;
            if (rd_energy != 4'hf) begin
                s_d.rdat = s_q.pub[rd_energy];
            end else begin
                unique case (idx)
                    `EAIS_IDX_MODE:  s_d.rdat = {24'h0, s_q.mode};
                    `EAIS_IDX_WIRE:  s_d.rdat = {30'h0, s_q.wire_cd};
                    `EAIS_IDX_LCLEN: s_d.rdat = {16'h0, s_q.lclen};
                    `EAIS_IDX_ZXCNT: s_d.rdat = {16'h0, s_q.zxcnt};
                    `EAIS_IDX_VBRMS: s_d.rdat = 32'(s_q.vbrms);
                    default:         s_d.rdat = 32'h0;
                endcase
            end
        end
        if (req && wb_we_i) begin
            if (idx == `EAIS_IDX_MODE && wb_sel_i[0]) begin
                // Reserved bit never stores; var select held without reactive
                s_d.mode = wb_dat_i[7:0] & `EAIS_MODE_WMASK;
                if (!HAS_REACTIVE) begin
                    s_d.mode[`EAIS_MODE_REACT] = 1'b0;
                end
            end
            if (idx == `EAIS_IDX_WIRE && wb_sel_i[0]) begin
                s_d.wire_cd = wb_dat_i[1:0];
            end
            if (idx == `EAIS_IDX_LCLEN) begin
                if (wb_sel_i[0]) begin
                    s_d.lclen[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    s_d.lclen[15:8] = wb_dat_i[15:8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.mode <= `EAIS_MODE_RST & (HAS_REACTIVE ? 8'hff : 8'hfd);
            s_q.eff <= 7'(`EAIS_MODE_RST);
            s_q.wire_cd <= `EAIS_WIRE_RST;
            s_q.lclen <= `EAIS_LCLEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o             = s_q.rdat;
    assign wb_ack_o             = s_q.ack;
    assign vb_sel_o             = sel_if.vb_sel;
    assign wiring_config_code_o = s_q.wire_cd;
    assign line_cycle_end_o     = s_q.lc_end;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence seq_mode_write;
        req && wb_we_i && idx == `EAIS_IDX_MODE && wb_sel_i[0];
    endsequence
    sequence seq_read_energy0;
        rd_clr && rd_energy == 4'h0 && !s_q.eff[0] && !sel_if.prod_valid;
    endsequence
    sequence seq_lc_quiet;
        s_q.eff[0] && !period_end && !rd_clr;
    endsequence

    a_mode_write: assert property (seq_mode_write |=>
        s_q.mode[6:0] == $past(wb_dat_i[6:0] & 7'h7f & (HAS_REACTIVE ? 7'h7f : 7'h7d)))
        else $error("mode register write not stored");
    a_reserved_bit: assert property (!s_q.mode[`EAIS_MODE_RSVD])
        else $error("reserved mode bit set");
    a_no_reactive: assert property (!HAS_REACTIVE |-> !s_q.mode[1])
        else $error("var line-cycle bit set without reactive");
    a_read_clears: assert property (seq_read_energy0 |=>
        s_q.pub[0] == 32'h0 && s_q.rdat == $past(s_q.pub[0]))
        else $error("read-clear did not return then clear");
    a_lc_holds: assert property (seq_lc_quiet |=>
        $stable(s_q.pub[0]) ##0 $stable(s_q.eff[0]))
        else $error("line-cycle register moved mid period");
    a_lc_update: assert property (s_q.eff[0] && period_end |=>
        s_q.pub[0] == $past(s_q.run[0]) + $past(sel_if.prod_valid
            ? to_acc(sel_if.prod[0]) : 32'h0) && s_q.run[0] == 32'h0)
        else $error("line-cycle period end update wrong");
    a_zx_count: assert property (!period_end |=>
        s_q.zxcnt == $past(zx_sum[15:0]))
        else $error("zero-crossing count wrong");
    a_vb_rms: assert property (sample_valid_i |=>
        s_q.vbrms == $past(volt_rms_i[1]))
        else $error("phase B rms not captured");
    a_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not single cycle");
    // Wiring code lands on the edge that takes the write
    a_wire_write: assert property (
        req && wb_we_i && idx == `EAIS_IDX_WIRE && wb_sel_i[0] |=>
        s_q.wire_cd == $past(wb_dat_i[1:0]))
        else $error("wiring code write not stored");
    // Period end pulses once and restarts the crossing count
    a_end_pulse: assert property (period_end |=>
        line_cycle_end_o && s_q.zxcnt == 16'h0)
        else $error("period end not signalled");
endmodule

// file: verification/eais_top_tb_top.sv
`timescale 1ns/1ps
`include "eais_defines.svh"
module eais_top_tb_top;
    import eais_pkg::*;
    localparam int W = 16;
    logic              clk_i          = 1'b0;
    logic              resetn_i       = 1'b0;
    logic              wb_cyc_i       = 1'b0;
    logic              wb_stb_i       = 1'b0;
    logic              wb_we_i        = 1'b0;
    logic [17:0]       wb_adr_i       = 18'h0;
    logic [3:0]        wb_sel_i       = 4'h0;
    logic [31:0]       wb_dat_i       = 32'h0;
    logic              sample_valid_i = 1'b0;
    logic [2:0][W-1:0] volt_i         = '0;
    logic [2:0][W-1:0] curr_i         = '0;
    logic [2:0][W-1:0] curr_quad_i    = '0;
    logic [2:0][W-1:0] volt_rms_i     = '0;
    logic [2:0][W-1:0] curr_rms_i     = '0;
    logic [2:0]        zero_cross_i   = 3'h0;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    logic [W:0]        vb_sel_o;
    logic [1:0]        wiring_config_code_o;
    logic              line_cycle_end_o;
    logic [31:0]       en [9];
    logic [31:0]       rd;
    logic [31:0]       held;
    logic [W:0]        vb;
    logic [W:0]        vk;
    int                err_total = 0;
    int                compares  = 0;
    int                ends      = 0;
    int                seed      = 32'hfff9;

    eais_top #(.W(W)) eais_top_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i),
        .volt_i(volt_i), .curr_i(curr_i), .curr_quad_i(curr_quad_i),
        .volt_rms_i(volt_rms_i), .curr_rms_i(curr_rms_i),
        .zero_cross_i(zero_cross_i), .vb_sel_o(vb_sel_o),
        .wiring_config_code_o(wiring_config_code_o),
        .line_cycle_end_o(line_cycle_end_o)
    );

    // ------------------------------------------------------------------
    // Clock and period-end pulse counter
    // ------------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (line_cycle_end_o === 1'b1) ends++;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Sign extension keeps the model in the design's W+1 operand width
    function automatic logic [W:0] sx(input logic [W-1:0] x);
        return {x[W-1], x};
    endfunction

    function automatic logic [31:0] top32(input logic signed [W:0] a,
                                          input logic signed [W:0] b);
        logic signed [2*W+1:0] p;
        p = a * b;
        return p[2*W+1 -: 32];
    endfunction

    task automatic report_and_stop();
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single cycle; a missing ack ends the run
    task automatic wb(input logic we, input logic [15:0] idx,
                      input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (wb_ack_o === 1'b0 && n >= 20) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        check($sformatf("reg %h", idx), rd, exp);
    endtask

    // One random sample set; model adds products when acc is set
    task automatic sample(input logic [1:0] code, input logic acc);
        for (int k = 0; k < 3; k++) begin
            volt_i[k]      <= W'($random(seed));
            curr_i[k]      <= W'($random(seed));
            curr_quad_i[k] <= W'($random(seed));
            volt_rms_i[k]  <= W'($random(seed));
            curr_rms_i[k]  <= W'($random(seed));
        end
        sample_valid_i <= 1'b1;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        vb = (code == 2'h0) ? sx(volt_i[1]) :
             (code == 2'h1) ? sx(volt_i[0]) - sx(volt_i[2]) :
             (code == 2'h2) ? -sx(volt_i[0]) - sx(volt_i[2]) :
             -sx(volt_i[0]);
        @(posedge clk_i);
        check("phase b voltage", 32'(vb_sel_o), 32'(vb));
        for (int k = 0; k < 3; k++) begin
            vk = (k == 1) ? vb : sx(volt_i[k]);
            if (acc) begin
                en[k]   += top32(vk, sx(curr_i[k]));
                en[3+k] += top32(vk, sx(curr_quad_i[k]));
                en[6+k] += top32({1'b0, volt_rms_i[k]},
                                 {1'b0, curr_rms_i[k]});
            end
        end
    endtask

    // Zero-crossing toggles on the phases set in m
    task automatic toggle(input logic [2:0] m, input int n);
        repeat (n) begin
            zero_cross_i <= zero_cross_i ^ m;
            repeat (8) @(posedge clk_i);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        en = '{default: 32'h0};
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rdchk(`EAIS_IDX_MODE, 32'h78);
        rdchk(`EAIS_IDX_WIRE, 32'h0);
        wb(1'b1, `EAIS_IDX_MODE, 32'hff);
        rdchk(`EAIS_IDX_MODE, 32'h7f);
        wb(1'b1, `EAIS_IDX_MODE, 32'h78);
        rdchk(16'he7ff, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `EAIS_IDX_WIRE, 32'(c));
            check("wiring", 32'(wiring_config_code_o), 32'(c));
            sample(2'(c), 1'b1);
            sample(2'(c), 1'b1);
            rdchk(`EAIS_IDX_VBRMS, 32'(volt_rms_i[1]));
            for (int k = 0; k < 9; k++) begin
                rdchk(`EAIS_IDX_ENERGY0 + 16'(k), en[k]);
            end
            rdchk(`EAIS_IDX_ENERGY0 + 16'h1, 32'h0);
            en = '{default: 32'h0};
        end
        wb(1'b1, `EAIS_IDX_ENERGY0, 32'h1234);
        rdchk(`EAIS_IDX_ENERGY0, 32'h0);
        // Read-clear off: energy survives repeated reads
        wb(1'b1, `EAIS_IDX_MODE, 32'h38);
        sample(2'h3, 1'b1);
        rdchk(`EAIS_IDX_ENERGY0, en[0]);
        rdchk(`EAIS_IDX_ENERGY0, en[0]);
        // Line-cycle, phase A crossings only, period of four
        wb(1'b1, `EAIS_IDX_LCLEN, 32'h4);
        wb(1'b1, `EAIS_IDX_MODE, 32'h0f);
        sample(2'h3, 1'b0);
        held = 32'(ends);
        toggle(3'h2, 5);
        check("period ends", 32'(ends), held);
        toggle(3'h1, 4);
        check("period ends", 32'(ends), held + 1);
        wb(1'b0, `EAIS_IDX_ENERGY0, 32'h0);
        held = rd;
        sample(2'h3, 1'b0);
        rdchk(`EAIS_IDX_ENERGY0, held);
        // All three phases enabled: crossings add up
        wb(1'b1, `EAIS_IDX_LCLEN, 32'h6);
        wb(1'b1, `EAIS_IDX_MODE, 32'h3f);
        sample(2'h3, 1'b0);
        held = 32'(ends);
        toggle(3'h7, 1);
        rdchk(`EAIS_IDX_ZXCNT, 32'h3);
        toggle(3'h7, 1);
        check("period ends", 32'(ends), held + 1);
        report_and_stop();
    end
endmodule
